/* design/tfm_core.sv */
// thermistor fault monitor: sampling sequencer, fault flags, fet drives
// assumes all comparator inputs are synchronous to REF_CLK
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps

module tfm_core
	import tfm_pkg::*;
#(
	parameter int unsigned SAMPLE_CYC     = SAMPLE_MS * CYC_PER_MS,
	parameter int unsigned FILTER_CYC     = FILTER_MS * CYC_PER_MS,
	parameter int unsigned OV_PERIOD_CYC  = OV_PERIOD_MS * CYC_PER_MS,
	parameter int unsigned OV_RELEASE_CYC = OV_RELEASE_MS * CYC_PER_MS
) (
	// clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       RST_B,
	// register port
	input  wire logic [3:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	output logic      [7:0] REG_RDATA,
	// sense pin comparators
	input  wire logic       SENSE_EXT_PU_HI,
	input  wire logic       SENSE_HOT_LO,
	input  wire logic       SENSE_OPEN_HI,
	input  wire logic       SENSE_SHORT_LO,
	// charger sense and overvoltage fault
	input  wire logic       CHRG_SENSE_HI,
	input  wire logic       OV_FAULT,
	// sense pin drive, open drain
	output logic            SENSE_PD_O,
	output logic            SENSE_PD_OE,
	output logic            SENSE_SINK_EN,
	// thermistor bias output
	output logic            THERM_BIAS_EN,
	// fet drives and mode
	output logic            CHARGE_FET_DRV,
	output logic            DISCHARGE_FET_DRV,
	output logic            SHDN_MODE,
	// interrupt
	output logic            IRQ
);

	localparam logic [31:0] SAMPLE_LAST = 32'(SAMPLE_CYC - 1);
	localparam logic [31:0] FILTER_END  = 32'(FILTER_CYC);
	localparam logic [15:0] SETTLE_LAST = SETTLE_CYC - 16'h0001;

	typedef struct packed {
		tfm_state_t  st;
		logic [15:0] tmr;
		logic [31:0] ivl;
		logic [31:0] opn_cnt;
		logic        ext;
		logic        bias;
		logic        sink;
		logic        hot;
		logic        opn;
		logic        shdn;
		logic        charge_fet_drive;
		logic        discharge_fet_drive;
		logic        chrg_seen;
		logic [1:0]  ctrl;
		logic [3:0]  ists;
		logic [3:0]  imask;
		logic        irq;
		logic [7:0]  rdata;
	} tfm_core_t;

	tfm_core_t r_reg;
	tfm_core_t r_next;
	logic      pd_oe;
	logic      ov_active;

	// the pulldown follows the fault only while the overvoltage enable bit is set; the monitor disable bit is not consulted
	assign ov_active = r_reg.ctrl[CTRL_OV_SIG] & OV_FAULT;

	tfm_ov_release #(
		.PERIOD_CYC  (OV_PERIOD_CYC),
		.RELEASE_CYC (OV_RELEASE_CYC)
	) u_ov_release (
		.clk       (REF_CLK),
		.rst_b     (RST_B),
		.ov_active (ov_active),
		.pd_oe     (pd_oe)
	);

	// next state: register port, sequencer, fault flags, interrupts
	always_comb begin
		logic [3:0] ev;
		logic [3:0] w1c;
		logic       mon_dis;
		logic       chrg_ok;
		ev      = 4'h0;
		w1c     = 4'h0;
		mon_dis = r_reg.ctrl[CTRL_MON_DIS];
		// a pin we hold low cannot show a charger, so ignore it meanwhile
		chrg_ok = CHRG_SENSE_HI & ~pd_oe;
		r_next  = r_reg;

		// register writes; interrupt status is write one to clear
		if (REG_WR) begin
			case (REG_ADDR)
				ADDR_CTRL:  r_next.ctrl  = REG_WDATA[1:0];
				ADDR_ISTS:  w1c          = REG_WDATA[3:0];
				ADDR_IMASK: r_next.imask = REG_WDATA[3:0];
				default:    ;
			endcase
		end

		// read data stands only in the cycle after the strobe
		r_next.rdata = 8'h00;
		if (REG_RD) begin
			case (REG_ADDR)
				ADDR_CTRL:   r_next.rdata = {6'h00, r_reg.ctrl};
				ADDR_STATUS: r_next.rdata = {pd_oe, r_reg.ext, r_reg.shdn, r_reg.opn,
							     r_reg.hot, r_reg.bias, r_reg.charge_fet_drive, r_reg.discharge_fet_drive};
				ADDR_ISTS:   r_next.rdata = {4'h0, r_reg.ists};
				ADDR_IMASK:  r_next.rdata = {4'h0, r_reg.imask};
				default:     r_next.rdata = 8'h00;
			endcase
		end

		// charger arrival edge, sampled only while the pin is free
		if (!pd_oe) begin
			r_next.chrg_seen = CHRG_SENSE_HI;
			if (CHRG_SENSE_HI && !r_reg.chrg_seen) begin
				ev[IRQ_CHRG] = 1'b1;
			end
		end

		// open fault filter: counts cycles since the last open reading
		if (r_reg.opn_cnt != FILTER_END) begin
			r_next.opn_cnt = r_reg.opn_cnt + 32'h0000_0001;
		end else if (r_reg.opn && r_reg.st != ST_SHDN) begin
			r_next.opn = 1'b0;
		end

		case (r_reg.st)
			ST_IDLE: begin
				// no sampling while disabled or while the pin is held low
				if (mon_dis) begin
					r_next.hot = 1'b0;
					r_next.opn = 1'b0;
				end
				if (r_reg.ivl == SAMPLE_LAST) begin
					r_next.ivl = 32'h0000_0000;
					if (!mon_dis && !pd_oe) begin
						r_next.st   = ST_EXT;
						r_next.sink = 1'b1;
						r_next.tmr  = SETTLE_LAST;
					end
				end else begin
					r_next.ivl = r_reg.ivl + 32'h0000_0001;
				end
			end
			ST_EXT: begin
				// weak sink applied; a high pin means someone else biases it
				if (r_reg.tmr != 16'h0000) begin
					r_next.tmr = r_reg.tmr - 16'h0001;
				end else begin
					r_next.sink = 1'b0;
					r_next.ext  = SENSE_EXT_PU_HI;
					if (SENSE_EXT_PU_HI) begin
						r_next.st = ST_EVAL;
					end else begin
						r_next.st   = ST_BIAS;
						r_next.bias = 1'b1;
						r_next.tmr  = SETTLE_LAST;
					end
				end
			end
			ST_BIAS: begin
				if (r_reg.tmr != 16'h0000) begin
					r_next.tmr = r_reg.tmr - 16'h0001;
				end else begin
					r_next.st = ST_EVAL;
				end
			end
			ST_EVAL: begin
				// one reading, judged short first, then open, then hot
				r_next.bias = 1'b0;
				r_next.st   = ST_IDLE;
				if (SENSE_SHORT_LO) begin
					r_next.st        = ST_SHDN;
					r_next.shdn      = 1'b1;
					ev[IRQ_SHORT]    = 1'b1;
				end else if (SENSE_OPEN_HI) begin
					r_next.opn       = 1'b1;
					r_next.opn_cnt   = 32'h0000_0000;
					r_next.hot       = 1'b0;
					ev[IRQ_OPEN]     = ~r_reg.opn;
				end else begin
					r_next.hot       = SENSE_HOT_LO;
					ev[IRQ_HOT]      = SENSE_HOT_LO & ~r_reg.hot;
				end
			end
			ST_SHDN: begin
				// low power: only a charger connection brings us back
				r_next.bias = 1'b0;
				r_next.sink = 1'b0;
				if (chrg_ok) begin
					r_next.st   = ST_IDLE;
					r_next.shdn = 1'b0;
					r_next.hot  = 1'b0;
					r_next.opn  = 1'b0;
					r_next.ivl  = 32'h0000_0000;
				end
			end
			default: begin
				r_next.st   = ST_IDLE;
				r_next.bias = 1'b0;
				r_next.sink = 1'b0;
			end
		endcase

		// any temperature fault opens both fets
		r_next.charge_fet_drive = ~(r_next.hot | r_next.opn | r_next.shdn);
		r_next.discharge_fet_drive = ~(r_next.hot | r_next.opn | r_next.shdn);

		// a new event beats a clear landing in the same cycle
		r_next.ists = (r_reg.ists & ~w1c) | ev;
		r_next.irq  = |(r_next.ists & r_next.imask);
	end

	// state register
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			r_reg       <= '0;
			r_reg.st    <= ST_IDLE;
			r_reg.ctrl  <= CTRL_RESET;
			r_reg.imask <= IMASK_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from flops; the open-drain level is always low
	assign REG_RDATA         = r_reg.rdata;
	assign SENSE_PD_O        = 1'b0;
	assign SENSE_PD_OE       = pd_oe;
	assign SENSE_SINK_EN     = r_reg.sink;
	assign THERM_BIAS_EN     = r_reg.bias;
	assign CHARGE_FET_DRV    = r_reg.charge_fet_drive;
	assign DISCHARGE_FET_DRV = r_reg.discharge_fet_drive;
	assign SHDN_MODE         = r_reg.shdn;
	assign IRQ               = r_reg.irq;

	property p_bias_window;
		@(posedge REF_CLK) disable iff (!RST_B)
		THERM_BIAS_EN |-> (r_reg.st == ST_BIAS || r_reg.st == ST_EVAL);
	endproperty
	a_bias_window: assert property (p_bias_window) else $error("bias on outside sample");

	property p_hot_fets;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_reg.st == ST_EVAL && SENSE_HOT_LO && !SENSE_SHORT_LO && !SENSE_OPEN_HI)
		|=> (!CHARGE_FET_DRV && !DISCHARGE_FET_DRV && !SHDN_MODE && r_reg.hot);
	endproperty
	a_hot_fets: assert property (p_hot_fets) else $error("hot reading left fets on");

	property p_open_clear;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_reg.opn && r_reg.opn_cnt == FILTER_END && r_reg.st == ST_IDLE) |=> !r_reg.opn;
	endproperty
	a_open_clear: assert property (p_open_clear) else $error("open fault did not clear");

	property p_short_shdn;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_reg.st == ST_EVAL && SENSE_SHORT_LO)
		|=> (SHDN_MODE && !CHARGE_FET_DRV && !DISCHARGE_FET_DRV && r_reg.st == ST_SHDN)
		##1 (SHDN_MODE || $past(CHRG_SENSE_HI));
	endproperty
	a_short_shdn: assert property (p_short_shdn) else $error("short did not shut down");

	property p_ext_no_bias;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_reg.st == ST_EXT && r_reg.tmr == 16'h0000 && SENSE_EXT_PU_HI)
		|=> !THERM_BIAS_EN ##1 (!THERM_BIAS_EN && r_reg.st != ST_EVAL);
	endproperty
	a_ext_no_bias: assert property (p_ext_no_bias) else $error("bias with external supply");

	property p_open_awake;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_reg.st == ST_EVAL && SENSE_OPEN_HI && !SENSE_SHORT_LO)
		|=> (r_reg.opn && !SHDN_MODE && !CHARGE_FET_DRV && r_reg.st == ST_IDLE);
	endproperty
	a_open_awake: assert property (p_open_awake) else $error("open fault handled wrongly");

	property p_ov_pull;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_reg.ctrl[CTRL_OV_SIG] && OV_FAULT && !$past(ov_active)) |=> SENSE_PD_OE;
	endproperty
	a_ov_pull: assert property (p_ov_pull) else $error("no pulldown on overvoltage");

	property p_pd_no_wake;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_reg.st == ST_SHDN && SENSE_PD_OE) |=> r_reg.st == ST_SHDN;
	endproperty
	a_pd_no_wake: assert property (p_pd_no_wake) else $error("woke while pin held");

	property p_chrg_wake;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_reg.st == ST_SHDN && CHRG_SENSE_HI && !SENSE_PD_OE) |=> (!SHDN_MODE && r_reg.st == ST_IDLE);
	endproperty
	a_chrg_wake: assert property (p_chrg_wake) else $error("charger did not wake");

	property p_seq_order;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_reg.st == ST_EVAL) |-> $past(r_reg.st) inside {ST_EXT, ST_BIAS} ##1 !THERM_BIAS_EN;
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("sample sequence out of order");

	property p_fets_follow;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_reg.hot || r_reg.opn || r_reg.shdn) |-> (!CHARGE_FET_DRV && !DISCHARGE_FET_DRV);
	endproperty
	a_fets_follow: assert property (p_fets_follow) else $error("fet on during fault");

	property p_sink_window;
		@(posedge REF_CLK) disable iff (!RST_B)
		SENSE_SINK_EN |-> (r_reg.st == ST_EXT && !THERM_BIAS_EN);
	endproperty
	a_sink_window: assert property (p_sink_window) else $error("sink outside bias test");

	c_hot: cover property (@(posedge REF_CLK) disable iff (!RST_B) $rose(r_reg.hot));
	c_shdn_wake: cover property (@(posedge REF_CLK) disable iff (!RST_B) $fell(SHDN_MODE));
	c_ext: cover property (@(posedge REF_CLK) disable iff (!RST_B) $rose(r_reg.ext));

endmodule

/* design/tfm_ov_release.sv */
// thermistor fault monitor: overvoltage pulldown of the sense pin
// assumes ov_active is synchronous to clk and already gated by the enable bit
`timescale 1ns/10ps

module tfm_ov_release
	import tfm_pkg::*;
#(
	parameter int unsigned PERIOD_CYC  = OV_PERIOD_MS * CYC_PER_MS,
	parameter int unsigned RELEASE_CYC = OV_RELEASE_MS * CYC_PER_MS
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// request and pin drive
	input  wire logic ov_active,
	output logic      pd_oe
);

	localparam logic [31:0] HOLD_LAST = 32'(PERIOD_CYC - RELEASE_CYC - 1);
	localparam logic [31:0] PER_LAST  = 32'(PERIOD_CYC - 1);

	typedef struct packed {
		logic [31:0] cnt;
		logic        pd;
	} tfm_ovr_t;

	tfm_ovr_t r_reg;
	tfm_ovr_t r_next;

	// hold low first, then release for the tail of each period
	always_comb begin
		r_next = r_reg;
		if (ov_active) begin
			r_next.cnt = (r_reg.cnt == PER_LAST) ? 32'h0000_0000 : r_reg.cnt + 32'h0000_0001;
			r_next.pd  = (r_next.cnt <= HOLD_LAST);
		end else begin
			// parked at the period end so the first hold after a fault is a full one
			r_next.cnt = PER_LAST;
			r_next.pd  = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r_reg.cnt <= PER_LAST;
			r_reg.pd  <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign pd_oe = r_reg.pd;

	property p_ov_release;
		@(posedge clk) disable iff (!rst_b)
		(ov_active && r_reg.cnt == HOLD_LAST) ##1 ov_active |-> !pd_oe;
	endproperty
	a_ov_release: assert property (p_ov_release) else $error("sense pin not released");

	property p_ov_rehold;
		@(posedge clk) disable iff (!rst_b)
		(ov_active && r_reg.cnt == PER_LAST) ##1 ov_active |-> pd_oe;
	endproperty
	a_ov_rehold: assert property (p_ov_rehold) else $error("pulldown not resumed");

	property p_ov_drop;
		@(posedge clk) disable iff (!rst_b)
		!ov_active |=> !pd_oe;
	endproperty
	a_ov_drop: assert property (p_ov_drop) else $error("pulldown without fault");

	c_ov_window: cover property (@(posedge clk) disable iff (!rst_b) $fell(pd_oe) && ov_active);

endmodule

/* design/tfm_pkg.sv */
// thermistor fault monitor: shared constants, register map and state types
// assumes a 100 MHz reference clock; every count here is derived from that rate
package tfm_pkg;

	// clock rate and derived unit counts
	localparam int unsigned CLK_MHZ    = 100;
	localparam int unsigned CYC_PER_US = CLK_MHZ;
	localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;

	// bias and sink settle time before a reading is trusted
	localparam int unsigned SETTLE_US  = 10;
	localparam logic [15:0] SETTLE_CYC = 16'(SETTLE_US * CYC_PER_US);

	// default intervals, in milliseconds as printed
	localparam int unsigned SAMPLE_MS     = 1000;
	localparam int unsigned FILTER_MS     = 1000;
	localparam int unsigned OV_PERIOD_MS  = 4000;
	localparam int unsigned OV_RELEASE_MS = 200;

	// register offsets on the plain register port
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_ISTS   = 4'h2;
	localparam logic [3:0] ADDR_IMASK  = 4'h3;

	// control bits
	localparam int unsigned CTRL_OV_SIG  = 0;
	localparam int unsigned CTRL_MON_DIS = 1;
	localparam logic [1:0]  CTRL_RESET   = 2'h0;

	// interrupt status and mask layout
	localparam int unsigned IRQ_HOT   = 0;
	localparam int unsigned IRQ_OPEN  = 1;
	localparam int unsigned IRQ_SHORT = 2;
	localparam int unsigned IRQ_CHRG  = 3;
	localparam logic [3:0]  IMASK_RESET = 4'h0;

	// sampling sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXT,
		ST_BIAS,
		ST_EVAL,
		ST_SHDN
	} tfm_state_t;

endpackage

/* tb/tfm_therm_model.sv */
// stand-in for the pack thermistor and the charger sense line
// assumes the bench picks the thermistor condition, external bias and charger
`timescale 1ns/10ps

module tfm_therm_model (
	// pin drive from the monitor
	input  wire logic       bias_en,
	input  wire logic       pd_oe,
	// scenario controls: 0 normal, 1 hot, 2 open, 3 shorted
	input  wire logic [1:0] cond,
	input  wire logic       ext_bias,
	input  wire logic       charger,
	// comparator levels seen by the monitor
	output logic            ext_pu_hi,
	output logic            hot_lo,
	output logic            open_hi,
	output logic            short_lo,
	output logic            chrg_hi
);
	logic low;

	// an unbiased or pulled pin sits at ground, so it reads as shorted and hot
	assign low       = pd_oe | ~(bias_en | ext_bias);
	assign ext_pu_hi = ext_bias & ~pd_oe;
	assign hot_lo    = low | (cond == 2'h1) | (cond == 2'h3);
	assign open_hi   = ~low & (cond == 2'h2);
	assign short_lo  = low | (cond == 2'h3);
	// separate charger sense pin follows the charger directly
	assign chrg_hi   = charger;
endmodule

/* tb/thermistor_fault_monitor_tb_top.sv */
// self-checking bench for the thermistor fault monitor
// assumes tfm_core with shortened intervals and the thermistor stand-in
`timescale 1ns/10ps

module thermistor_fault_monitor_tb_top;
	localparam int SMP = 50;
	localparam int FLT = 200;
	localparam int OVP = 400;
	localparam int OVR = 20;

	// clock, reset and register port
	logic       REF_CLK   = 1'b0;
	logic       RST_B     = 1'b0;
	logic [3:0] REG_ADDR  = 4'h0;
	logic [7:0] REG_WDATA = 8'h00;
	logic       REG_WR    = 1'b0;
	logic       REG_RD    = 1'b0;
	logic [7:0] REG_RDATA;
	// pins and scenario controls
	logic       ext_pu, hot, opn, shrt, chrg, pd_oe, sink, bias, charge_fet_drive, discharge_fet_drive, shdn, irq;
	logic       pd_o;
	logic       ov        = 1'b0;
	logic [1:0] cond      = 2'h0;
	logic       ext_bias  = 1'b0;
	logic       charger   = 1'b0;
	int         fails     = 0;
	int         n_compared = 0;
	logic [7:0] rd;

	always #5 REF_CLK = ~REF_CLK;

	tfm_core #(.SAMPLE_CYC(SMP), .FILTER_CYC(FLT), .OV_PERIOD_CYC(OVP), .OV_RELEASE_CYC(OVR))
	i_dut (
		.REF_CLK(REF_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.SENSE_EXT_PU_HI(ext_pu), .SENSE_HOT_LO(hot), .SENSE_OPEN_HI(opn),
		.SENSE_SHORT_LO(shrt), .CHRG_SENSE_HI(chrg), .OV_FAULT(ov),
		.SENSE_PD_O(pd_o), .SENSE_PD_OE(pd_oe), .SENSE_SINK_EN(sink), .THERM_BIAS_EN(bias),
		.CHARGE_FET_DRV(charge_fet_drive), .DISCHARGE_FET_DRV(discharge_fet_drive), .SHDN_MODE(shdn), .IRQ(irq)
	);

	tfm_therm_model i_therm (
		.bias_en(bias), .pd_oe(pd_oe), .cond(cond), .ext_bias(ext_bias), .charger(charger),
		.ext_pu_hi(ext_pu), .hot_lo(hot), .open_hi(opn), .short_lo(shrt), .chrg_hi(chrg)
	);

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk_mode(input logic [2:0] e);
		chk("shdn/chg/dsg", {13'h0000, e}, {13'h0000, shdn, charge_fet_drive, discharge_fet_drive});
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: return sink;
			1: return bias;
			2: return pd_oe;
			default: return shdn;
		endcase
	endfunction

	// bounded wait on a monitor output; running out ends the run
	task automatic wait_sig(input int k, input logic v, input int lim);
		int n = 0;
		while (pick(k) !== v) begin
			@(posedge REF_CLK);
			#1;
			n++;
			if (n > lim) begin
				chk("wait bound", 16'h0000, 16'h0001);
				give_verdict();
			end
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		REG_ADDR  <= a;
		REG_WDATA <= d;
		REG_WR    <= 1'b1;
		@(posedge REF_CLK);
		REG_WR    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_RD   <= 1'b1;
		@(posedge REF_CLK);
		REG_RD   <= 1'b0;
		#1;
		rd = REG_RDATA & m;
		chk("rdata", {8'h00, e}, {8'h00, rd});
	endtask

	task automatic set_cond(input logic [1:0] c, input logic e, input logic ch);
		@(posedge REF_CLK);
		cond     <= c;
		ext_bias <= e;
		charger  <= ch;
	endtask

	// one whole sampling interval, ending once the bias is back off, or with ext set 1100 cycles after the sink drops
	task automatic do_sample(input logic ext);
		wait_sig(0, 1'b1, 3000);
		chk("bias in sink", 16'h0000, {15'h0000, bias});
		wait_sig(0, 1'b0, 1100);
		if (ext) begin
			repeat (1100) begin
				@(posedge REF_CLK);
				#1;
				chk("bias ext", 16'h0000, {15'h0000, bias});
			end
		end else begin
			chk("bias on", 16'h0001, {15'h0000, bias});
			wait_sig(1, 1'b0, 1100);
		end
		repeat (2) @(posedge REF_CLK);
		#1;
	endtask

	task automatic t_reset();
		chk_mode(3'h3);
		reg_rd(4'h0, 8'hff, 8'h00);
		reg_rd(4'h3, 8'hff, 8'h00);
		reg_wr(4'h9, 8'hff);
		reg_rd(4'h9, 8'hff, 8'h00);
	endtask

	task automatic t_hot();
		reg_wr(4'h3, 8'h01);
		set_cond(2'h1, 1'b0, 1'b0);
		do_sample(1'b0);
		chk_mode(3'h0);
		chk("irq", 16'h0001, {15'h0000, irq});
		reg_rd(4'h2, 8'h01, 8'h01);
		reg_wr(4'h2, 8'h01);
		@(posedge REF_CLK);
		#1;
		chk("irq clr", 16'h0000, {15'h0000, irq});
		set_cond(2'h0, 1'b0, 1'b0);
		do_sample(1'b0);
		chk_mode(3'h3);
	endtask

	// open reading: protection while awake, masked event keeps the line low
	task automatic t_open();
		set_cond(2'h2, 1'b0, 1'b0);
		do_sample(1'b0);
		chk_mode(3'h0);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		reg_rd(4'h2, 8'h02, 8'h02);
		set_cond(2'h0, 1'b0, 1'b0);
		do_sample(1'b0);
		chk_mode(3'h3);
		reg_wr(4'h2, 8'h0f);
	endtask

	task automatic t_ext();
		set_cond(2'h0, 1'b1, 1'b0);
		do_sample(1'b1);
		chk_mode(3'h3);
		set_cond(2'h0, 1'b0, 1'b0);
	endtask

	task automatic t_short();
		reg_wr(4'h3, 8'h0c);
		set_cond(2'h3, 1'b0, 1'b0);
		do_sample(1'b0);
		chk_mode(3'h4);
		set_cond(2'h0, 1'b0, 1'b0);
		repeat (3 * SMP) @(posedge REF_CLK);
		#1;
		chk_mode(3'h4);
		// charger while the pin is held: stays down until the release window
		reg_wr(4'h0, 8'h01);
		ov <= 1'b1;
		set_cond(2'h0, 1'b0, 1'b1);
		repeat (20) @(posedge REF_CLK);
		#1;
		chk_mode(3'h4);
		wait_sig(3, 1'b0, OVP);
		chk("wake pd", 16'h0000, {15'h0000, pd_oe});
		reg_rd(4'h2, 8'h0c, 8'h0c);
		chk("irq", 16'h0001, {15'h0000, irq});
		reg_wr(4'h2, 8'h0f);
		ov <= 1'b0;
		set_cond(2'h0, 1'b0, 1'b0);
	endtask

	// pulldown on overvoltage, periodic release for charger sampling
	task automatic t_ov();
		int n = 0;
		reg_wr(4'h0, 8'h02);
		@(posedge REF_CLK);
		ov <= 1'b1;
		repeat (5) @(posedge REF_CLK);
		#1;
		chk("pd off", 16'h0000, {15'h0000, pd_oe});
		reg_wr(4'h0, 8'h03);
		@(posedge REF_CLK);
		#1;
		chk("pd on", 16'h0001, {15'h0000, pd_oe});
		chk("pd level", 16'h0000, {15'h0000, pd_o});
		while (pd_oe === 1'b1 && n < 1000) begin
			@(posedge REF_CLK);
			charger <= (n >= 100 && n < 110);
			#1;
			n++;
		end
		chk("held", 16'(OVP - OVR), 16'(n));
		reg_rd(4'h2, 8'h08, 8'h00);
		// the status read already used two of the released cycles
		n = 2;
		while (pd_oe === 1'b0 && n < 1000) begin
			@(posedge REF_CLK);
			charger <= 1'b1;
			#1;
			n++;
		end
		chk("released", 16'(OVR), 16'(n));
		reg_rd(4'h2, 8'h08, 8'h08);
		@(posedge REF_CLK);
		ov <= 1'b0;
		@(posedge REF_CLK);
		#1;
		chk("pd drop", 16'h0000, {15'h0000, pd_oe});
		reg_wr(4'h0, 8'h00);
		reg_wr(4'h2, 8'h0f);
	endtask

	initial begin
		repeat (5) @(posedge REF_CLK);
		RST_B <= 1'b1;
		@(posedge REF_CLK);
		#1;
		t_reset();
		t_hot();
		t_open();
		t_ext();
		t_short();
		t_ov();
		give_verdict();
	end
endmodule
